// >>> hw/cmpc_top.sv
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module cmpc_top
  import cmpc_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [7:0]        rdata,
  input  wire logic              cmp_raw,
  input  wire logic              timer_clk_src,
  input  wire logic              port_direction,
  output logic                   cmp_pin_o,
  output logic                   cmp_pin_oe,
  output logic                   cmp_enable,
  output logic                   cmp_speed_power_sel,
  output logic                   cmp_hysteresis_en,
  output logic      [1:0]        cmp_pos_input_sel,
  output logic      [1:0]        cmp_neg_input_sel,
  output logic                   cmp_result,
  output logic                   cmp_irq_set
);

  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic       raw_s1;
  logic       raw_s2;
  logic       tmr_s1;
  logic       tmr_s2;
  logic       next_result;

  cmpc_edge_if tmr_edge ();
  cmpc_edge_if res_edge ();

  // Address decode and bus strobes.
  wire        sel_c0  = (addr == ADDR_W'(CMPC_CTRL0_ADDR));
  wire        sel_c1  = (addr == ADDR_W'(CMPC_CTRL1_ADDR));
  wire        wr_c0   = ce & wr & sel_c0;
  wire        wr_c1   = ce & wr & sel_c1;

  // Control fields.
  wire        en_bit   = ctrl0[CMPC_C0_ENABLE_BIT];
  wire        oe_bit   = ctrl0[CMPC_C0_OE_BIT];
  wire        inv_bit  = ctrl0[CMPC_C0_INV_BIT];
  wire        sync_bit = ctrl0[CMPC_C0_SYNC_BIT];
  wire        rise_en  = ctrl1[CMPC_C1_RISE_BIT];
  wire        fall_en  = ctrl1[CMPC_C1_FALL_BIT];

  // Read view: the live result sits in its bit, unimplemented bits read zero.
  wire [7:0]  c0_view  = ctrl0 | ({7'h00, cmp_result} << CMPC_C0_RESULT_BIT);
  wire [7:0]  rd_mux   = sel_c0 ? c0_view : (sel_c1 ? ctrl1 : 8'h00);

  // Control registers, written only while the clock enable is high.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl0 <= CMPC_CTRL0_RESET;
      ctrl1 <= CMPC_CTRL1_RESET;
    end else begin
      if (wr_c0) begin
        ctrl0 <= wdata & CMPC_CTRL0_WMASK;
      end
      if (wr_c1) begin
        ctrl1 <= wdata & CMPC_CTRL1_WMASK;
      end
    end
  end

  // Read data stands from the enabled edge that samples the read strobe until the next enabled edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= rd ? rd_mux : 8'h00;
    end
  end

  // Two-stage synchronisers for the analog result and the timer clock source.
  always_ff @(posedge clk) begin
    if (rst) begin
      raw_s1 <= 1'b0;
      raw_s2 <= 1'b0;
      tmr_s1 <= 1'b0;
      tmr_s2 <= 1'b0;
    end else if (ce) begin
      raw_s1 <= cmp_raw;
      raw_s2 <= raw_s1;
      tmr_s1 <= timer_clk_src;
      tmr_s2 <= tmr_s1;
    end
  end

  // Timer clock edge finder.
  assign tmr_edge.level = tmr_s2;

  cmpc_edge u_tmr_edge (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .e   (tmr_edge.det)
  );

  // Polarity applied to the comparator decision; a disabled comparator reads low, in sync mode only after the next timer falling edge.
  wire        polarised = en_bit & (raw_s2 ^ inv_bit);
  wire        res_load  = ~sync_bit | tmr_edge.fall;

  always_comb begin
    next_result = res_load ? polarised : cmp_result;
  end

  // Output register; in sync mode it only moves at a timer falling edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      cmp_result <= 1'b0;
    end else if (ce) begin
      cmp_result <= next_result;
    end
  end

  // Result edge finder feeding the interrupt flag request.
  assign res_edge.level = cmp_result;

  cmpc_edge u_res_edge (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .e   (res_edge.det)
  );

  assign cmp_irq_set = ce & ((rise_en & res_edge.rise) | (fall_en & res_edge.fall));

  // Pin drive: output enable and direction both needed, comparator enable ignored.
  assign cmp_pin_o  = oe_bit & cmp_result;
  assign cmp_pin_oe = oe_bit & ~port_direction;

  // Mode bits to the analog core.
  assign cmp_enable          = en_bit;
  assign cmp_speed_power_sel = ctrl0[CMPC_C0_SP_BIT];
  assign cmp_hysteresis_en   = ctrl0[CMPC_C0_HYS_BIT];
  assign cmp_pos_input_sel   = ctrl1[CMPC_C1_POS_LSB +: 2];
  assign cmp_neg_input_sel   = ctrl1[CMPC_C1_NEG_LSB +: 2];

  // Checks on the block's own outputs.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_PIN_ROUTED: assert property (
    (wr_c0 && wdata[CMPC_C0_OE_BIT]) ##1 !port_direction |-> cmp_pin_oe && (cmp_pin_o == cmp_result)
  ) else $error("Result not driven on pin after output enable set.");

  AST_PIN_INTERNAL: assert property (
    (wr_c0 && !wdata[CMPC_C0_OE_BIT]) |=> !cmp_pin_oe && !cmp_pin_o
  ) else $error("Pin driven while output enable clear.");

  AST_INVERT: assert property (
    (ce && !sync_bit && en_bit) |=> (cmp_result == ($past(raw_s2) ^ $past(inv_bit)))
  ) else $error("Output polarity does not follow invert select.");

  AST_SPEED: assert property (
    wr_c0 |=> (cmp_speed_power_sel == $past(wdata[CMPC_C0_SP_BIT]))
  ) else $error("Speed/power select not taken from write.");

  AST_HYST: assert property (
    wr_c0 |=> (cmp_hysteresis_en == $past(wdata[CMPC_C0_HYS_BIT]))
  ) else $error("Hysteresis enable not taken from write.");

  AST_SYNC_HOLD: assert property (
    (sync_bit && !tmr_edge.fall) |=> $stable(cmp_result)
  ) else $error("Synced output moved without a timer falling edge.");

  AST_FALL_IRQ: assert property (
    (ce && $past(ce) && fall_en && $fell(cmp_result)) |-> cmp_irq_set
  ) else $error("Falling edge did not raise the interrupt flag.");

  AST_RISE_IRQ: assert property (
    (ce && $past(ce) && rise_en && $rose(cmp_result)) |-> cmp_irq_set
  ) else $error("Rising edge did not raise the interrupt flag.");

  AST_NO_IRQ: assert property (
    (!rise_en && !fall_en) |-> !cmp_irq_set
  ) else $error("Interrupt flag raised with both edge enables clear.");

  AST_PIN_DIR_INPUT: assert property (
    port_direction |-> !cmp_pin_oe
  ) else $error("Pin driven while the port direction is input.");

  AST_DISABLED_LOW: assert property (
    (ce && !en_bit && !sync_bit) |=> !cmp_result
  ) else $error("Disabled comparator produced a high result.");

  AST_SYNC_LOAD: assert property (
    (ce && sync_bit && tmr_edge.fall) |=> (cmp_result == ($past(en_bit) && ($past(raw_s2) != $past(inv_bit))))
  ) else $error("Synced output not loaded at a timer falling edge.");

  AST_FALL_ONLY: assert property (
    (ce && !fall_en && !res_edge.rise) |-> !cmp_irq_set
  ) else $error("Interrupt flag raised without an enabled edge.");

  AST_RISE_ONLY: assert property (
    (ce && !rise_en && !res_edge.fall) |-> !cmp_irq_set
  ) else $error("Interrupt flag raised without an enabled edge.");

  AST_SP_HOLD: assert property (
    !wr_c0 |=> $stable(cmp_speed_power_sel)
  ) else $error("Speed/power select moved without a write.");

  AST_HYS_HOLD: assert property (
    !wr_c0 |=> $stable(cmp_hysteresis_en)
  ) else $error("Hysteresis enable moved without a write.");

endmodule

// >>> hw/cmpc_pkg.sv
package cmpc_pkg;

  // Register indices on the byte-wide control port.
  localparam logic [3:0] CMPC_CTRL0_ADDR = 4'h0;
  localparam logic [3:0] CMPC_CTRL1_ADDR = 4'h1;

  // Field positions in comparator_control_0.
  localparam int CMPC_C0_ENABLE_BIT = 7;
  localparam int CMPC_C0_RESULT_BIT = 6;
  localparam int CMPC_C0_OE_BIT     = 5;
  localparam int CMPC_C0_INV_BIT    = 4;
  localparam int CMPC_C0_SP_BIT     = 2;
  localparam int CMPC_C0_HYS_BIT    = 1;
  localparam int CMPC_C0_SYNC_BIT   = 0;

  // Field positions in comparator_control_1.
  localparam int CMPC_C1_RISE_BIT   = 7;
  localparam int CMPC_C1_FALL_BIT   = 6;
  localparam int CMPC_C1_POS_LSB    = 4;
  localparam int CMPC_C1_NEG_LSB    = 0;

  // Reset values and writable masks; the result bit and unimplemented bits are not writable.
  localparam logic [7:0] CMPC_CTRL0_RESET = 8'h04;
  localparam logic [7:0] CMPC_CTRL1_RESET = 8'h00;
  localparam logic [7:0] CMPC_CTRL0_WMASK = 8'hB7;
  localparam logic [7:0] CMPC_CTRL1_WMASK = 8'hF3;

endpackage

// >>> hw/cmpc_edge_if.sv
`timescale 1ns/1ps
interface cmpc_edge_if;
  logic level;
  logic rise;
  logic fall;

  modport det  (input level, output rise, output fall);
  modport user (output level, input rise, input fall);
endinterface

// >>> hw/cmpc_edge.sv
`timescale 1ns/1ps
module cmpc_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  cmpc_edge_if.det e
);

  logic prev;

  // Holds the level seen at the last enabled edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      prev <= 1'b0;
    end else if (ce) begin
      prev <= e.level;
    end
  end

  // Transition strobes against the remembered level.
  assign e.rise = e.level & ~prev;
  assign e.fall = ~e.level & prev;

endmodule

// >>> sim/cmpc_partner.sv
`timescale 1ns/1ps
module cmpc_partner (
  input  wire logic clk,
  input  wire logic level,
  input  wire logic tmr_run,
  output logic      cmp_raw,
  output logic      timer_clk_src
);
  logic [1:0] div;

  // The analog decision follows the level that the bench asks for.
  assign cmp_raw = level;

  // The timer source idles high and toggles every four clocks only while it runs.
  always_ff @(posedge clk) begin
    div <= tmr_run ? div + 2'h1 : 2'h0;
    if (!tmr_run) begin
      timer_clk_src <= 1'b1;
    end else if (div == 2'h3) begin
      timer_clk_src <= ~timer_clk_src;
    end
  end
endmodule

// >>> sim/cmpc_top_tb.sv
`timescale 1ns/1ps
module cmpc_top_tb;
  import cmpc_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0;
  logic       port_direction = 1'b0, lvl = 1'b0, run = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic       cmp_raw, timer_clk_src, pin_o, pin_oe, en, sp, hys, res, irq;
  logic [1:0] pos_sel, neg_sel;
  int         n_mismatch = 0, n_tests = 0;

  cmpc_top dut_u (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cmp_raw(cmp_raw), .timer_clk_src(timer_clk_src), .port_direction(port_direction), .cmp_pin_o(pin_o),
    .cmp_pin_oe(pin_oe), .cmp_enable(en), .cmp_speed_power_sel(sp), .cmp_hysteresis_en(hys),
    .cmp_pos_input_sel(pos_sel), .cmp_neg_input_sel(neg_sel), .cmp_result(res), .cmp_irq_set(irq));
  cmpc_partner far_u (.clk(clk), .level(lvl), .tmr_run(run), .cmp_raw(cmp_raw), .timer_clk_src(timer_clk_src));

  // The clock runs at 10 MHz.
  initial begin
    forever #50 clk = ~clk;
  end

  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // One write cycle; its effect is settled when it returns, one time step after the clock edge.
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // One read cycle; the data stand only in the cycle after the strobe.
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", e, rdata);
    @(posedge clk);
    #1;
    chk("rdata_idle", 8'h00, rdata);
  endtask

  // Waits a bounded time for the result to reach a level.
  task automatic wait_res(input logic v);
    int i;
    for (i = 0; i < 60 && res !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk("cmp_result", {7'h0, v}, {7'h0, res});
    if (i == 60) close_out();
  endtask

  // Moves the analog level and counts set pulses over twelve cycles.
  task automatic irq_win(input logic v, input logic [7:0] e);
    logic [7:0] n;
    n = 8'h00;
    @(posedge clk);
    lvl <= v;
    repeat (12) begin
      @(posedge clk);
      #1;
      if (irq === 1'b1) n++;
    end
    chk("irq_count", e, n);
  endtask

  // Main sequence of register and comparator scenarios.
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk(CMPC_CTRL0_ADDR, 8'h04);
    chk("speed_power", 8'h01, {7'h0, sp});
    chk("enable_reset", 8'h00, {7'h0, en});
    rd_chk(CMPC_CTRL1_ADDR, 8'h00);
    rd_chk(4'h2, 8'h00);
    wr_reg(CMPC_CTRL0_ADDR, 8'h26);
    chk("pin_oe", 8'h01, {7'h0, pin_oe});
    chk("hysteresis", 8'h01, {7'h0, hys});
    @(posedge clk) port_direction <= 1'b1;
    @(posedge clk) #1;
    chk("pin_oe_input", 8'h00, {7'h0, pin_oe});
    @(posedge clk) port_direction <= 1'b0;
    rd_chk(CMPC_CTRL0_ADDR, 8'h26);
    wr_reg(CMPC_CTRL0_ADDR, 8'h00);
    chk("pin_oe_off", 8'h00, {7'h0, pin_oe});
    chk("speed_low", 8'h00, {7'h0, sp});
    chk("hyst_off", 8'h00, {7'h0, hys});
    wr_reg(CMPC_CTRL0_ADDR, 8'hBE);
    wait_res(1'b1);
    chk("pin_o", 8'h01, {7'h0, pin_o});
    rd_chk(CMPC_CTRL0_ADDR, 8'hF6);
    chk("enable_on", 8'h01, {7'h0, en});
    wr_reg(CMPC_CTRL0_ADDR, 8'h90);
    chk("pin_oe_internal", 8'h00, {7'h0, pin_oe});
    chk("pin_o_internal", 8'h00, {7'h0, pin_o});
    rd_chk(CMPC_CTRL0_ADDR, 8'hD0);
    wr_reg(CMPC_CTRL0_ADDR, 8'hA0);
    wait_res(1'b0);
    wr_reg(CMPC_CTRL1_ADDR, 8'hFF);
    rd_chk(CMPC_CTRL1_ADDR, 8'hF3);
    chk("input_sel", 8'h0F, {4'h0, pos_sel, neg_sel});
    wr_reg(CMPC_CTRL1_ADDR, 8'h80);
    irq_win(1'b1, 8'h01);
    irq_win(1'b0, 8'h00);
    wr_reg(CMPC_CTRL1_ADDR, 8'h40);
    irq_win(1'b1, 8'h00);
    irq_win(1'b0, 8'h01);
    @(posedge clk) ce <= 1'b0;
    wr_reg(CMPC_CTRL1_ADDR, 8'h33);
    @(posedge clk) ce <= 1'b1;
    rd_chk(CMPC_CTRL1_ADDR, 8'h40);
    wr_reg(CMPC_CTRL0_ADDR, 8'h81);
    @(posedge clk) lvl <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk("sync_hold", 8'h00, {7'h0, res});
    @(posedge clk) run <= 1'b1;
    wait_res(1'b1);
    close_out();
  end
endmodule
